// File: dv/pwpia_props.sv
/*
 Port checker for the protect bank.
 Assumes it is bound into pwpia_top and sees its ports only.
*/
module pwpia_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire pwpia_pkg::pwpia_req_s req,
	input wire logic ack,
	input wire logic communication_fault,
	input wire logic protect_pin,
	input wire logic addr_select_pin_zero,
	input wire logic addr_select_pin_one,
	input wire logic [6:0] device_addr,
	input wire pwpia_pkg::pwpia_nv_s nv_image_out,
	input wire logic nv_store,
	input wire pwpia_pkg::pwpia_int_s int_req
);
	import pwpia_pkg::*;
	logic wr, l1, l2, ok1, ok2, az, a1;
	logic [6:0] ofs;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	assign az = addr_select_pin_zero;
	assign a1 = addr_select_pin_one;
	assign ofs = {3'h0, a1 & az, a1 & !az, 1'b0, !a1 & az};
	assign wr = req.valid && req.write;
	assign l1 = nv_image_out.wp == 8'h80;
	assign l2 = !l1 && (protect_pin || nv_image_out.wp == 8'h40);
	assign ok1 = req.code inside {8'h10, 8'h00, 8'hbd, 8'h15, 8'hc8};
	assign ok2 = ok1 || req.code inside {8'h01, 8'h03, 8'hcc, 8'hd9, 8'he4};
	a_ack_follows_req: assert property (req.valid |=> ack)
		else $error("ack missing after request");
	a_ack_only_req: assert property (!req.valid |=> !ack)
		else $error("ack without request");
	a_addr_sum: assert property (device_addr == nv_image_out.base + ofs)
		else $error("device address not base plus offset");
	a_level_one_gate: assert property (wr && l1 && !ok1 |-> !int_req.valid)
		else $error("write passed level one");
	a_level_two_gate: assert property (wr && l2 && !ok2 |-> !int_req.valid)
		else $error("write passed level two");
	a_protect_wr: assert property (wr && req.code == 8'h10
		|=> nv_image_out.wp == $past(req.wdata[7:0]))
		else $error("protect level not written");
	a_mask_wr: assert property (wr && req.code == 8'he4 && !l1
		|=> nv_image_out.gmask == $past(req.wdata[1:0]))
		else $error("mask not written");
	a_fault_ack: assert property (communication_fault |-> ack)
		else $error("fault outside ack");
	a_store_strobe: assert property (
		nv_store == (wr && req.code == 8'h15))
		else $error("store strobe mismatch");
	cover property (wr && l1 && req.code == 8'hc9);
	cover property (wr && l1 && req.code == 8'he4);
	cover property (communication_fault);
	cover property (int_req.valid && int_req.write);
endmodule

bind pwpia_top pwpia_props u_props (.*);

// File: dv/pwpia_store.sv
/*
 Model of the internal register store behind the bank.
 Assumes one request per cycle and answers in the request cycle.
*/
module pwpia_store (
	input wire logic clk,
	input wire pwpia_pkg::pwpia_req_s req,
	input wire pwpia_pkg::pwpia_int_s int_req,
	output logic [15:0] int_rdata,
	output logic int_paged,
	output logic int_global
);
	import pwpia_pkg::*;
	logic [15:0] mem [64];
	logic [5:0] idx;
	logic [15:0] pat;
	initial foreach (mem[i]) mem[i] = 16'h0000;
	assign idx = {int_req.page[1:0], int_req.code[3:0]};
	assign pat = {int_req.page[2:0], int_req.index[3:0], int_req.code};
	// Stored XOR pattern: unwritten places read page, block word and code
	assign int_rdata = int_req.valid ? mem[idx] ^ pat : {16{clk}};
	assign int_global = req.code inside {8'h01, 8'h03};
	assign int_paged = int_global || req.code[7:5] == 3'h1;
	always @(posedge clk) begin
		if (int_req.valid && int_req.write)
			mem[idx] <= int_req.wdata ^ pat;
	end
endmodule

// File: dv/tb_top.sv
/*
 Bench for the protect and indirect bank: command tasks and checks.
 Assumes the store model and the bound checker are compiled alongside.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pwpia_pkg::*;
	logic clk = 0, rst_n = 0, protect_pin = 0, nv_load = 0, block_abort = 0;
	logic addr_select_pin_zero = 0, addr_select_pin_one = 0;
	logic ack, communication_fault, nv_store, int_paged, int_global, gf;
	pwpia_req_s req = '0;
	pwpia_nv_s nv_image_in = '0;
	pwpia_nv_s nv_image_out;
	pwpia_int_s int_req;
	logic [15:0] rdata, int_rdata, got;
	logic [6:0] device_addr, base_e;
	logic [1:0] mask_e;
	logic [15:0] op_e = 16'h0021;
	logic [6:0] ofs [4] = '{7'h0, 7'h1, 7'h4, 7'h8};
	logic [7:0] wps [7] = '{8'h00, 8'h40, 8'h80, 8'h00, 8'h40, 8'h80, 8'h20};
	int num_errors = 0, checks_done = 0;
	always #2 clk = ~clk;
	pwpia_top u_dut (.*);
	pwpia_store u_store (.*);
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		req <= '{1'b1, w, c, d};
		@(negedge clk);
		req.valid <= 1'b0;
		chk("ack", 16'h1, {15'h0, ack});
		got = rdata;
		gf = communication_fault;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		cmd(1'b0, c, 16'h0);
		chk("read data", e, got);
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd(8'h10, 16'h0000);
		rd(8'he4, 16'h0003);
		rd(8'he6, 16'h005c);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			{addr_select_pin_one, addr_select_pin_zero} = 2'(i);
			#1 chk("addr", {9'h0, 7'h5c + ofs[i]}, {9'h0, device_addr});
		end
		@(negedge clk);
		{addr_select_pin_one, addr_select_pin_zero} = 2'h0;
		cmd(1'b1, 8'he6, 16'h00ff);
		rd(8'he6, 16'h007f);
		cmd(1'b1, 8'he4, 16'h00fe);
		rd(8'he4, 16'h0002);
		base_e = 7'h7f;
		mask_e = 2'h2;
		// Pin high on cases 3 to 5; last case is a reserved level value
		for (int i = 0; i < 7; i++) begin
			protect_pin = i > 2 && i < 6;
			cmd(1'b1, 8'h10, {8'h0, wps[i]});
			rd(8'h10, {8'h0, wps[i]});
			cmd(1'b1, 8'he6, 16'h0010 + 16'(i));
			if (!protect_pin && wps[i] != 8'h40 && wps[i] != 8'h80) begin
				base_e = 7'h10 + 7'(i);
				op_e = 16'h0100 + 16'(i);
			end
			cmd(1'b1, 8'he4, {14'h0, 2'(i)});
			if (wps[i] != 8'h80)
				mask_e = 2'(i);
			rd(8'he6, {9'h0, base_e});
			rd(8'he4, {14'h0, mask_e});
			cmd(1'b1, 8'h21, 16'h0100 + 16'(i));
			rd(8'h21, op_e);
		end
		protect_pin = 1'b0;
		cmd(1'b1, 8'h10, 16'h0000);
		cmd(1'b1, 8'hc8, 16'h8203);
		rd(8'hc8, 16'h0203);
		rd(8'hc9, 16'h2003);
		cmd(1'b1, 8'hc8, 16'h4405);
		rd(8'hca, 16'h4005);
		rd(8'hc9, 16'h2203);
		rd(8'hc9, 16'h2403);
		rd(8'h00, 16'h0000);
		cmd(1'b1, 8'hc8, 16'h0bf6);
		cmd(1'b1, 8'hc8, 16'h0207);
		cmd(1'b1, 8'hc9, 16'h1234);
		rd(8'hc9, 16'h1234);
		cmd(1'b1, 8'hc8, 16'h002c);
		rd(8'hc9, 16'h0000);
		cmd(1'b1, 8'hc8, 16'h4208);
		cmd(1'b1, 8'hca, 16'h5555);
		rd(8'hca, 16'h2008);
		cmd(1'b1, 8'hc8, 16'h402d);
		rd(8'hca, 16'h0002);
		@(negedge clk);
		block_abort = 1'b1;
		@(negedge clk);
		block_abort = 1'b0;
		cmd(1'b1, 8'hc8, 16'h002c);
		rd(8'hc9, 16'h0001);
		cmd(1'b1, 8'h00, 16'h00ff);
		cmd(1'b1, 8'h20, 16'h0001);
		chk("fault", 16'h1, {15'h0, gf});
		cmd(1'b0, 8'h20, 16'h0000);
		chk("fault", 16'h1, {15'h0, gf});
		cmd(1'b1, 8'h01, 16'h0080);
		chk("fault", 16'h0, {15'h0, gf});
		cmd(1'b1, 8'h00, 16'h0000);
		nv_image_in = '{8'h80, 2'h1, 7'h10};
		nv_load = 1'b1;
		@(negedge clk);
		nv_load = 1'b0;
		rd(8'h10, 16'h0080);
		chk("addr", 16'h0010, {9'h0, device_addr});
		cmd(1'b1, 8'h15, 16'h0000);
		cmd(1'b1, 8'hc8, 16'h0010);
		cmd(1'b1, 8'hc9, 16'h0040);
		rd(8'hc9, 16'h0010);
		give_verdict;
	end
endmodule

// File: hdl/pwpia_map.svh
/*
 Command codes, field positions, reset values and special values of the
 write-protect and indirect-access bank. Definitions only; assumes the
 includer has nothing else by these names.
*/
`ifndef PWPIA_MAP_SVH
`define PWPIA_MAP_SVH

`define PWPIA_CMD_PAGE 8'h00
`define PWPIA_CMD_OPERATION 8'h01
`define PWPIA_CMD_CLEAR_FAULTS 8'h03
`define PWPIA_CMD_WP 8'h10
`define PWPIA_CMD_STORE_ALL 8'h15
`define PWPIA_CMD_IND_PTR 8'hc8
`define PWPIA_CMD_DATA_A 8'hc9
`define PWPIA_CMD_DATA_B 8'hca
`define PWPIA_CMD_CLR_ENERGY 8'hcc
`define PWPIA_CMD_NV_UNLOCK 8'hbd
`define PWPIA_CMD_GOOD_FORCE 8'hd9
`define PWPIA_CMD_GMASK 8'he4
`define PWPIA_CMD_BASE 8'he6

`define PWPIA_WP_LEVEL1 8'h80
`define PWPIA_WP_LEVEL2 8'h40
`define PWPIA_WP_NONE 8'h00
`define PWPIA_WP_RST 8'h00
`define PWPIA_GMASK_RST 2'h3
`define PWPIA_BASE_RST 7'h5c
`define PWPIA_PAGE_RST 8'h00
`define PWPIA_PAGE_GLOBAL 8'hff

`define PWPIA_PTR_ID 14
`define PWPIA_PTR_PAGE_HI 13
`define PWPIA_PTR_PAGE_LO 9
`define PWPIA_PTR_LOC_HI 8
`define PWPIA_PTR_LOC_LO 0
`define PWPIA_POKE_EN 14'h0bf6
`define PWPIA_POKE_DIS 14'h01f6
`define PWPIA_STAT_A 9'h02c
`define PWPIA_STAT_B 9'h02d

`define PWPIA_OFS_00 7'h00
`define PWPIA_OFS_01 7'h01
`define PWPIA_OFS_10 7'h04
`define PWPIA_OFS_11 7'h08

`endif

// File: hdl/pwpia_pkg.sv
/*
 Types shared by the bank and its surroundings: command request, internal
 register access, nonvolatile image and protection level.
 Assumes the map header is compiled alongside.
*/
package pwpia_pkg;
	typedef enum logic [1:0] {
		PWPIA_LVL_NONE = 2'b00,
		PWPIA_LVL_TWO = 2'b01,
		PWPIA_LVL_ONE = 2'b10
	} pwpia_level_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] wdata;
	} pwpia_req_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] page;
		logic [8:0] code;
		logic [15:0] wdata;
		logic [7:0] index;
		logic [1:0] chan;
	} pwpia_int_s;

	typedef struct packed {
		logic [7:0] wp;
		logic [1:0] gmask;
		logic [6:0] base;
	} pwpia_nv_s;
endpackage

// File: hdl/pwpia_top.sv
/*
 Write-protect gate, global page mask, bus address and indirect pointer
 bank. Assumes a PMBus target engine in front that presents decoded command
 reads and writes one at a time, and an internal register store behind that
 answers reads combinationally in the request cycle.
*/
// Function
// - Reads are never gated by protection; only writes are.
// - Level 1 accepts writes only to protect, page, unlock, store, pointer.
// - Level 2 adds operation, fault clear, energy clear, output force, mask.
// - Protect value zero allows all writes; other encodings are reserved.
// - Protect level is part of the image saved to and restored from storage.
// - Protect pin high applies the level 2 accepted set.
// - The more restrictive of pin and register levels applies.
// - Mask bits 1 and 0 enable channels for global page; bits 7:2 read zero.
// - Bus address is base plus pin-selected offset 0 to 8.
// - Base address resets to 0x5c, giving 0x64 with both pins high.
// - Base address bit 7 is read-only zero.
// - Block data is streamed one word per indirect word read.
// - Each extra host peeks internal registers with its own page.
// - Each extra host pokes internal registers with its own page.
// - Indirect access never touches the normal page select.
// - Pointer bit 14 selects which host context is updated.
// - Pointer bits 13:9 hold the per-host page, 0 to 31.
// - Pointer bits 8:0 hold the per-host internal location.
// - Pointer bit 15 reads back as zero.
// - With page 0xff, non-global paged writes drop; paged reads fault.
// - Each data register follows its own host's latest pointer write that is not a poke enable or disable code.
`include "pwpia_map.svh"
module pwpia_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire pwpia_pkg::pwpia_req_s req,
	output logic ack,
	output logic [15:0] rdata,
	output logic communication_fault,
	input wire logic protect_pin,
	input wire logic addr_select_pin_zero,
	input wire logic addr_select_pin_one,
	output logic [6:0] device_addr,
	input wire logic nv_load,
	input wire pwpia_pkg::pwpia_nv_s nv_image_in,
	output pwpia_pkg::pwpia_nv_s nv_image_out,
	output logic nv_store,
	output pwpia_pkg::pwpia_int_s int_req,
	input wire logic [15:0] int_rdata,
	input wire logic int_paged,
	input wire logic int_global,
	input wire logic block_abort
);
	import pwpia_pkg::*;

	logic [7:0] wp_q;
	logic [1:0] gmask_q;
	logic [6:0] base_q;
	logic [7:0] page_q;
	logic [14:0] ptr_q;
	logic [4:0] hpage_q [2];
	logic [8:0] hloc_q [2];
	logic [7:0] hidx_q [2];
	logic [1:0] poke_en_q;
	logic [1:0] poke_fail_q;
	logic [1:0] blk_fail_q;
	logic [15:0] rdata_q;
	logic ack_q;
	logic fault_q;
	logic [6:0] ofs;
	pwpia_level_e level;
	logic wr;
	logic rd;
	logic allowed;
	logic is_local;
	logic is_data;
	logic host;
	logic page_all;
	logic drop_fault;
	logic read_fault;
	logic is_poke_ctl;
	logic data_poke_ok;

	// Pointer write that matches a poke enable or disable code
	function automatic logic poke_ctl(input logic [15:0] v);
		return v[13:0] == `PWPIA_POKE_EN || v[13:0] == `PWPIA_POKE_DIS;
	endfunction

	// Accepted-command set for a protection level
	function automatic logic wr_ok(input pwpia_level_e l, input logic [7:0] c);
		logic one;
		logic two;
		one = c == `PWPIA_CMD_WP || c == `PWPIA_CMD_PAGE ||
			c == `PWPIA_CMD_NV_UNLOCK || c == `PWPIA_CMD_STORE_ALL ||
			c == `PWPIA_CMD_IND_PTR;
		two = one || c == `PWPIA_CMD_OPERATION ||
			c == `PWPIA_CMD_CLEAR_FAULTS || c == `PWPIA_CMD_CLR_ENERGY ||
			c == `PWPIA_CMD_GOOD_FORCE || c == `PWPIA_CMD_GMASK;
		case (l)
			PWPIA_LVL_ONE: return one;
			PWPIA_LVL_TWO: return two;
			default: return 1'b1;
		endcase
	endfunction

	// Stricter of pin and register; reserved values treated as unprotected
	always_comb begin
		level = PWPIA_LVL_NONE;
		if (wp_q == `PWPIA_WP_LEVEL1) begin
			level = PWPIA_LVL_ONE;
		end else if (wp_q == `PWPIA_WP_LEVEL2 || protect_pin) begin
			level = PWPIA_LVL_TWO;
		end
	end

	assign wr = req.valid && req.write;
	assign rd = req.valid && !req.write;
	assign is_data = req.code == `PWPIA_CMD_DATA_A ||
		req.code == `PWPIA_CMD_DATA_B;
	assign host = req.code == `PWPIA_CMD_DATA_B;
	assign is_local = is_data || req.code == `PWPIA_CMD_PAGE ||
		req.code == `PWPIA_CMD_WP || req.code == `PWPIA_CMD_GMASK ||
		req.code == `PWPIA_CMD_BASE || req.code == `PWPIA_CMD_IND_PTR;
	assign allowed = wr_ok(level, req.code);
	assign page_all = page_q == `PWPIA_PAGE_GLOBAL;
	assign drop_fault = wr && !is_local && page_all && int_paged &&
		!int_global;
	assign read_fault = rd && !is_local && page_all && int_paged;
	assign is_poke_ctl = poke_ctl(req.wdata);
	// A poke is a write to a data register, so it needs an open level too
	assign data_poke_ok = poke_en_q[host] && allowed;

	always_comb begin
		case ({addr_select_pin_one, addr_select_pin_zero})
			2'b00: ofs = `PWPIA_OFS_00;
			2'b01: ofs = `PWPIA_OFS_01;
			2'b10: ofs = `PWPIA_OFS_10;
			default: ofs = `PWPIA_OFS_11;
		endcase
	end
	assign device_addr = base_q + ofs;

	// Internal access: ordinary commands use the normal page, data
	// registers use the host's cached page and location
	always_comb begin
		int_req = '0;
		if (req.valid && is_data) begin
			int_req.page = hpage_q[host];
			int_req.code = hloc_q[host];
			int_req.index = hidx_q[host];
			int_req.chan = 2'b01 << hpage_q[host][0];
			int_req.wdata = req.wdata;
			int_req.write = req.write;
			int_req.valid = req.write ? data_poke_ok :
				hloc_q[host] != `PWPIA_STAT_A &&
				hloc_q[host] != `PWPIA_STAT_B;
		end else if (req.valid && !is_local) begin
			int_req.page = page_q[4:0];
			int_req.code = {1'b0, req.code};
			int_req.wdata = req.wdata;
			int_req.write = req.write;
			int_req.chan = page_all ? gmask_q : 2'b01 << page_q[0];
			int_req.valid = rd || (allowed && !drop_fault);
		end
	end

	// Protection level and restore
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= `PWPIA_WP_RST;
		end else if (nv_load) begin
			wp_q <= nv_image_in.wp;
		end else if (wr && req.code == `PWPIA_CMD_WP) begin
			wp_q <= req.wdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gmask_q <= `PWPIA_GMASK_RST;
			base_q <= `PWPIA_BASE_RST;
		end else if (nv_load) begin
			gmask_q <= nv_image_in.gmask;
			base_q <= nv_image_in.base;
		end else if (wr && allowed) begin
			if (req.code == `PWPIA_CMD_GMASK) begin
				gmask_q <= req.wdata[1:0];
			end
			if (req.code == `PWPIA_CMD_BASE) begin
				base_q <= req.wdata[6:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page_q <= `PWPIA_PAGE_RST;
		end else if (wr && req.code == `PWPIA_CMD_PAGE) begin
			page_q <= req.wdata[7:0];
		end
	end

	assign nv_image_out = '{wp: wp_q, gmask: gmask_q, base: base_q};
	assign nv_store = wr && req.code == `PWPIA_CMD_STORE_ALL;

	// Per-host pointer contexts
	generate
		for (genvar h = 0; h < 2; h++) begin : g_host
			logic sel_ptr;
			logic sel_data;
			assign sel_ptr = wr && req.code == `PWPIA_CMD_IND_PTR &&
				req.wdata[`PWPIA_PTR_ID] == 1'(h);
			assign sel_data = req.valid && is_data && host == 1'(h);

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					hpage_q[h] <= '0;
					hloc_q[h] <= '0;
				end else if (sel_ptr && !is_poke_ctl) begin
					hpage_q[h] <= req.wdata[`PWPIA_PTR_PAGE_HI:
						`PWPIA_PTR_PAGE_LO];
					hloc_q[h] <= req.wdata[`PWPIA_PTR_LOC_HI:
						`PWPIA_PTR_LOC_LO];
				end
			end

			// Block words advance one per read, restart on new pointer
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					hidx_q[h] <= '0;
				end else if (sel_ptr && !is_poke_ctl) begin
					hidx_q[h] <= '0;
				end else if (sel_data && !req.write) begin
					hidx_q[h] <= hidx_q[h] + 8'h01;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					poke_en_q[h] <= 1'b0;
				end else if (sel_ptr && is_poke_ctl) begin
					poke_en_q[h] <= req.wdata[13:0] == `PWPIA_POKE_EN;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					poke_fail_q[h] <= 1'b0;
				end else if (sel_data && req.write) begin
					poke_fail_q[h] <= !poke_en_q[h];
				end
			end

			// Abort sets win over the clear of a fresh pointer
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					blk_fail_q[h] <= 1'b0;
				end else if (block_abort) begin
					blk_fail_q[h] <= 1'b1;
				end else if (sel_ptr && !is_poke_ctl &&
					req.wdata[8:0] != `PWPIA_STAT_A &&
					req.wdata[8:0] != `PWPIA_STAT_B) begin
					blk_fail_q[h] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= '0;
		end else if (wr && req.code == `PWPIA_CMD_IND_PTR) begin
			ptr_q <= req.wdata[14:0];
		end
	end

	// Answer one cycle after the request; reads are never gated
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (rd) begin
			case (req.code)
				`PWPIA_CMD_PAGE: rdata_q <= {8'h00, page_q};
				`PWPIA_CMD_WP: rdata_q <= {8'h00, wp_q};
				`PWPIA_CMD_GMASK: rdata_q <= {14'h0000, gmask_q};
				`PWPIA_CMD_BASE: rdata_q <= {9'h000, base_q};
				`PWPIA_CMD_IND_PTR: rdata_q <= {1'b0, ptr_q};
				`PWPIA_CMD_DATA_A, `PWPIA_CMD_DATA_B: begin
					if (hloc_q[host] == `PWPIA_STAT_A) begin
						rdata_q <= {14'h0000, poke_fail_q[0], blk_fail_q[0]};
					end else if (hloc_q[host] == `PWPIA_STAT_B) begin
						rdata_q <= {14'h0000, poke_fail_q[1], blk_fail_q[1]};
					end else begin
						rdata_q <= int_rdata;
					end
				end
				default: rdata_q <= int_rdata;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			ack_q <= req.valid;
			fault_q <= drop_fault || read_fault;
		end
	end

	assign ack = ack_q;
	assign rdata = rdata_q;
	assign communication_fault = fault_q;
endmodule
